// *** shared/sbc_pkg.sv ***
// constants, state codes and stabilization counts for the standby controller
// assumes a 200 MHz machine clock and an 8-bit register port
`default_nettype none

package sbc_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam int CTRL_STOP_BIT = 7;
	localparam int CTRL_SLEEP_BIT = 6;
	localparam int CTRL_WATCH_BIT = 5;
	localparam int CTRL_PIN_SEL_BIT = 4;
	localparam int STAT_REJECT_BIT = 7;
	localparam int STAT_RSTWAKE_BIT = 6;
	localparam int STAT_MODE_LSB = 4;
	localparam logic PIN_SEL_RESET = 1'h0;

	// ----------------------------------------
	// clock modes as seen on the monitor field
	// ----------------------------------------
	localparam logic [1:0] MODE_SUB_CR = 2'h0;
	localparam logic [1:0] MODE_SUB_XTAL = 2'h1;
	localparam logic [1:0] MODE_MAIN_CR = 2'h2;
	localparam logic [1:0] MODE_MAIN_XTAL = 2'h3;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam logic [2:0] ENTRY_CYCLES = 3'h4;
	localparam int MAIN_XTAL_STAB_NS = 20000;
	localparam int SUB_XTAL_STAB_NS = 20000;
	localparam int MAIN_CR_STAB_NS = 1000;
	localparam int SUB_CR_STAB_NS = 2000;
	localparam logic [11:0] MAIN_XTAL_STAB_CYC =
		12'((MAIN_XTAL_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [11:0] SUB_XTAL_STAB_CYC =
		12'((SUB_XTAL_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [11:0] MAIN_CR_STAB_CYC =
		12'((MAIN_CR_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [11:0] SUB_CR_STAB_CYC =
		12'((SUB_CR_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ----------------------------------------
	// controller states
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_RST_SUB = 4'h0,
		ST_RST_MAIN = 4'h1,
		ST_RUN = 4'h2,
		ST_ENTRY = 4'h3,
		ST_SLEEP = 4'h4,
		ST_STOP = 4'h5,
		ST_TBT = 4'h6,
		ST_WATCH = 4'h7,
		ST_WAKE_STAB = 4'h8
	} state_type;

endpackage

`default_nettype wire

// *** rtl/stab_wait_timer.sv ***
// down counter for oscillation stabilization waits
// assumes load and count come from logic on the same clock
`default_nettype none

module stab_wait_timer (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_nrst,
	// control
	input wire logic i_load,
	input wire logic [11:0] i_cycles,
	// status
	output logic o_busy,
	output logic o_done
);

	typedef struct packed {
		logic [11:0] count;
		logic done;
	} timer_type;

	timer_type st;
	timer_type next_st;

	// ----------------------------------------
	// count down, pulse done after the last cycle
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		if (i_load) begin
			next_st.count = i_cycles;
		end else if (st.count != 12'h000) begin
			next_st.count = st.count - 12'h001;
			next_st.done = (st.count == 12'h001);
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			st <= '{count: sbc_pkg::SUB_CR_STAB_CYC, done: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign o_busy = (st.count != 12'h000);
	assign o_done = st.done;

endmodule

`default_nettype wire

// *** rtl/standby_mode_controller.sv ***
// standby mode controller: entry, wakeup and clock gating
// assumes interrupt sources, cpu flags and clock monitor on the same clock
//
// Summary of operation
// R1: four standby states chosen by control writes
// R2: interrupt or reset leaves standby, stop wake and reset wait stabilization
// R3: reset wakes in main cr mode, interrupt restores
// R4: pin select applies in stop, tbt, watch
// R5: select 0 holds pins, 1 floats them
// R6: four machine cycles from write to entry
// R7: software puts three nops after request
// R8: cpu keeps running during entry latency
// R9: software checks clock switch done first
// R10: pending interrupt discards the standby write
// R11: discard also when cpu masks interrupts
// R12: pending interrupt wakes regardless of cpu flags
// R13: service interrupt if accepted, else resume
// R14: after reset wait sub then main cr
// R15: sleep bit enters sleep
// R16: sleep left by reset or peripheral interrupt
// R17: stop bit enters stop
// R18: stop wake waits current mode stabilization
// R19: watch bit in main modes gives tbt
// R20: watch bit in sub modes gives watch
// R21: sleep gates cpu and watchdog clocks only
// R22: hardware watchdog keeps counting if enabled
// R23: stop over tbt or watch over sleep
`default_nettype none

module standby_mode_controller (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_nrst,
	// register port
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// interrupt and cpu side
	input wire logic i_irq_pending,
	input wire logic i_ccr_accepts,
	input wire logic [1:0] i_clock_mode_monitor,
	input wire logic i_hw_wdt_standby,
	output logic o_service_int,
	output logic o_resume_next,
	// clock gating
	output logic o_cpu_clk_en,
	output logic o_wdt_clk_en,
	output logic o_periph_clk_en,
	output logic o_main_osc_en,
	output logic o_sub_cr_keep,
	output logic o_hw_wdt_run,
	output logic o_force_main_cr,
	output logic [1:0] o_resume_mode,
	// pin control
	output logic o_pin_hold,
	output logic o_pin_hiz
);

	typedef struct packed {
		sbc_pkg::state_type state;
		sbc_pkg::state_type target;
		logic [2:0] entry_cnt;
		logic pin_hold_or_hiz_sel;
		logic [1:0] saved_mode;
		logic rejected;
		logic reset_wake;
		logic service;
		logic resume;
		logic [7:0] rdata;
	} ctrl_type;

	ctrl_type st;
	ctrl_type next_st;
	logic timer_load;
	logic [11:0] timer_cycles;
	logic timer_busy;
	logic timer_done;
	logic ctrl_wr;
	logic req_any;
	logic deep_state;
	logic standby_state;

	// ----------------------------------------
	// stabilization timer
	// ----------------------------------------
	stab_wait_timer timer (
		.i_mclk(i_mclk),
		.i_nrst(i_nrst),
		.i_load(timer_load),
		.i_cycles(timer_cycles),
		.o_busy(timer_busy),
		.o_done(timer_done)
	);

	function automatic logic [11:0] stab_for(input logic [1:0] mode);
		case (mode)
			sbc_pkg::MODE_MAIN_XTAL: stab_for = sbc_pkg::MAIN_XTAL_STAB_CYC;
			sbc_pkg::MODE_MAIN_CR: stab_for = sbc_pkg::MAIN_CR_STAB_CYC;
			sbc_pkg::MODE_SUB_XTAL: stab_for = sbc_pkg::SUB_XTAL_STAB_CYC;
			default: stab_for = sbc_pkg::SUB_CR_STAB_CYC;
		endcase
	endfunction

	assign ctrl_wr = i_wr && (i_addr == sbc_pkg::ADDR_CTRL);
	assign req_any = i_wdata[sbc_pkg::CTRL_STOP_BIT] || i_wdata[sbc_pkg::CTRL_SLEEP_BIT] ||
		i_wdata[sbc_pkg::CTRL_WATCH_BIT];
	assign deep_state = (st.state == sbc_pkg::ST_STOP) || (st.state == sbc_pkg::ST_TBT) ||
		(st.state == sbc_pkg::ST_WATCH);
	assign standby_state = deep_state || (st.state == sbc_pkg::ST_SLEEP);

	// ----------------------------------------
	// state machine and registers
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_st.service = 1'b0;
		next_st.resume = 1'b0;
		next_st.rdata = 8'h00;
		timer_load = 1'b0;
		timer_cycles = sbc_pkg::MAIN_CR_STAB_CYC;
		if (ctrl_wr) begin
			next_st.pin_hold_or_hiz_sel = i_wdata[sbc_pkg::CTRL_PIN_SEL_BIT];
		end
		if (i_rd && (i_addr == sbc_pkg::ADDR_STATUS)) begin
			next_st.rejected = 1'b0;
		end
		case (st.state)
			sbc_pkg::ST_RST_SUB: begin
				if (timer_done) begin // R14
					timer_load = 1'b1;
					timer_cycles = sbc_pkg::MAIN_CR_STAB_CYC;
					next_st.state = sbc_pkg::ST_RST_MAIN;
				end
			end
			sbc_pkg::ST_RST_MAIN: begin
				if (timer_done) begin // R14
					next_st.state = sbc_pkg::ST_RUN;
				end
			end
			sbc_pkg::ST_RUN: begin
				if (ctrl_wr && req_any) begin
					if (i_irq_pending) begin
						next_st.rejected = 1'b1; // R10 R11
					end else begin
						next_st.state = sbc_pkg::ST_ENTRY; // R1
						next_st.entry_cnt = sbc_pkg::ENTRY_CYCLES - 3'h1; // R6
						next_st.saved_mode = i_clock_mode_monitor; // R3
						next_st.reset_wake = 1'b0;
						if (i_wdata[sbc_pkg::CTRL_STOP_BIT]) begin
							next_st.target = sbc_pkg::ST_STOP; // R17 R23
						end else if (i_wdata[sbc_pkg::CTRL_WATCH_BIT]) begin
							if (i_clock_mode_monitor[1]) begin
								next_st.target = sbc_pkg::ST_TBT; // R19
							end else begin
								next_st.target = sbc_pkg::ST_WATCH; // R20
							end
						end else begin
							next_st.target = sbc_pkg::ST_SLEEP; // R15
						end
					end
				end
			end
			sbc_pkg::ST_ENTRY: begin
				if (st.entry_cnt == 3'h0) begin
					next_st.state = st.target; // R6 R8
				end else begin
					next_st.entry_cnt = st.entry_cnt - 3'h1;
				end
			end
			sbc_pkg::ST_SLEEP, sbc_pkg::ST_TBT, sbc_pkg::ST_WATCH: begin
				if (i_irq_pending) begin // R12 R16
					next_st.state = sbc_pkg::ST_RUN;
					next_st.service = i_ccr_accepts; // R13
					next_st.resume = !i_ccr_accepts;
				end
			end
			sbc_pkg::ST_STOP: begin
				if (i_irq_pending) begin // R2 R18
					timer_load = 1'b1;
					timer_cycles = stab_for(st.saved_mode);
					next_st.state = sbc_pkg::ST_WAKE_STAB;
				end
			end
			sbc_pkg::ST_WAKE_STAB: begin
				if (timer_done) begin // R18
					next_st.state = sbc_pkg::ST_RUN;
					next_st.service = i_ccr_accepts; // R13
					next_st.resume = !i_ccr_accepts;
				end
			end
			default: begin
				next_st.state = sbc_pkg::ST_RUN;
			end
		endcase
		if (i_rd) begin
			case (i_addr)
				sbc_pkg::ADDR_CTRL: begin
					next_st.rdata[sbc_pkg::CTRL_PIN_SEL_BIT] = st.pin_hold_or_hiz_sel;
				end
				sbc_pkg::ADDR_STATUS: begin
					next_st.rdata[3:0] = st.state;
					next_st.rdata[sbc_pkg::STAT_MODE_LSB +: 2] = st.saved_mode;
					next_st.rdata[sbc_pkg::STAT_RSTWAKE_BIT] = st.reset_wake;
					next_st.rdata[sbc_pkg::STAT_REJECT_BIT] = st.rejected;
				end
				default: begin
					next_st.rdata = 8'h00;
				end
			endcase
		end
		if (st.state == sbc_pkg::ST_RUN && ctrl_wr && req_any && i_irq_pending) begin
			next_st.rejected = 1'b1;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			st <= '{state: sbc_pkg::ST_RST_SUB, target: sbc_pkg::ST_SLEEP, entry_cnt: 3'h0,
				pin_hold_or_hiz_sel: sbc_pkg::PIN_SEL_RESET, saved_mode: sbc_pkg::MODE_MAIN_CR,
				rejected: 1'b0, reset_wake: 1'b1, service: 1'b0, resume: 1'b0, rdata: 8'h00};
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign o_rdata = st.rdata;
	assign o_service_int = st.service;
	assign o_resume_next = st.resume;
	assign o_cpu_clk_en = (st.state == sbc_pkg::ST_RUN) || (st.state == sbc_pkg::ST_ENTRY); // R21
	assign o_wdt_clk_en = o_cpu_clk_en; // R21
	assign o_periph_clk_en = o_cpu_clk_en || (st.state == sbc_pkg::ST_SLEEP); // R21
	assign o_main_osc_en = !((st.state == sbc_pkg::ST_STOP) || (st.state == sbc_pkg::ST_WATCH));
	assign o_sub_cr_keep = standby_state && i_hw_wdt_standby; // R22
	assign o_hw_wdt_run = !standby_state || i_hw_wdt_standby; // R22
	assign o_force_main_cr = (st.state == sbc_pkg::ST_RST_SUB) ||
		(st.state == sbc_pkg::ST_RST_MAIN); // R3 R14
	assign o_resume_mode = st.reset_wake ? sbc_pkg::MODE_MAIN_CR : st.saved_mode; // R3
	assign o_pin_hold = deep_state && !st.pin_hold_or_hiz_sel; // R4 R5
	assign o_pin_hiz = deep_state && st.pin_hold_or_hiz_sel; // R4 R5

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_nrst);

	entry_latency_a: assert property ( // R6
		(st.state == sbc_pkg::ST_RUN && ctrl_wr && req_any && !i_irq_pending) |->
		##1 (st.state == sbc_pkg::ST_ENTRY)[*4] ##1 standby_state)
		else $error("standby entry not after four cycles");

	reject_write_a: assert property ( // R10
		(st.state == sbc_pkg::ST_RUN && ctrl_wr && req_any && i_irq_pending) |=>
		(st.state == sbc_pkg::ST_RUN) && st.rejected)
		else $error("standby write taken while interrupt pending");

	stop_first_a: assert property ( // R23
		(st.state == sbc_pkg::ST_RUN && ctrl_wr && !i_irq_pending &&
		i_wdata[sbc_pkg::CTRL_STOP_BIT]) |-> ##5 (st.state == sbc_pkg::ST_STOP))
		else $error("stop request not honoured first");

	sleep_entry_a: assert property ( // R15
		(st.state == sbc_pkg::ST_RUN && ctrl_wr && !i_irq_pending &&
		i_wdata[7:5] == 3'h2) |-> ##5 (st.state == sbc_pkg::ST_SLEEP))
		else $error("sleep request did not enter sleep");

	tbt_watch_a: assert property ( // R19
		(st.state == sbc_pkg::ST_RUN && ctrl_wr && !i_irq_pending && i_wdata[7:5] == 3'h1) |->
		##5 (st.state == ($past(i_clock_mode_monitor[1], 5) ? sbc_pkg::ST_TBT :
		sbc_pkg::ST_WATCH)))
		else $error("watch bit chose wrong state");

	sleep_wake_a: assert property ( // R16
		(st.state == sbc_pkg::ST_SLEEP && i_irq_pending) |=>
		(st.state == sbc_pkg::ST_RUN) && (o_service_int != o_resume_next))
		else $error("sleep not left on interrupt");

	stop_stab_a: assert property ( // R18
		(st.state == sbc_pkg::ST_STOP && i_irq_pending) |=>
		(st.state == sbc_pkg::ST_WAKE_STAB) && !o_cpu_clk_en && timer_busy)
		else $error("stop wake skipped stabilization");

	sleep_gate_a: assert property ( // R21
		(st.state == sbc_pkg::ST_SLEEP) |->
		!o_cpu_clk_en && !o_wdt_clk_en && o_periph_clk_en)
		else $error("sleep clock gating wrong");

	pin_state_a: assert property ( // R5
		deep_state |-> (o_pin_hiz == st.pin_hold_or_hiz_sel) && (o_pin_hold != o_pin_hiz))
		else $error("pin hold or float wrong");

	service_a: assert property ( // R13
		(st.state == sbc_pkg::ST_WAKE_STAB && timer_done) |=>
		(o_service_int == $past(i_ccr_accepts)) && (st.state == sbc_pkg::ST_RUN))
		else $error("wake service decision wrong");

	resume_mode_a: assert property ( // R3
		(st.state == sbc_pkg::ST_RUN && ctrl_wr && req_any && !i_irq_pending) |=>
		!st.reset_wake && (o_resume_mode == $past(i_clock_mode_monitor)))
		else $error("interrupt wake mode not saved");

	boot_sub_a: assert property ( // R14
		(st.state == sbc_pkg::ST_RST_SUB && timer_done) |=>
		(st.state == sbc_pkg::ST_RST_MAIN) && timer_busy && o_force_main_cr)
		else $error("reset wait skipped main cr stabilization");

	boot_run_a: assert property ( // R14
		(st.state == sbc_pkg::ST_RST_MAIN && timer_done) |=>
		(st.state == sbc_pkg::ST_RUN) && !o_force_main_cr &&
		(o_resume_mode == sbc_pkg::MODE_MAIN_CR))
		else $error("reset wake not in main cr mode");

	deep_wake_a: assert property ( // R12
		((st.state == sbc_pkg::ST_TBT || st.state == sbc_pkg::ST_WATCH) && i_irq_pending) |=>
		(st.state == sbc_pkg::ST_RUN) && (o_service_int == $past(i_ccr_accepts)) &&
		(o_resume_next != o_service_int))
		else $error("tbt or watch not left on interrupt");

	standby_hold_a: assert property ( // R2
		(standby_state && !i_irq_pending) |=> (st.state == $past(st.state)))
		else $error("standby left without interrupt");

	wdt_standby_a: assert property ( // R22
		standby_state |-> (o_sub_cr_keep == i_hw_wdt_standby) &&
		(o_hw_wdt_run == i_hw_wdt_standby))
		else $error("hardware watchdog standby control wrong");

	osc_stopped_a: assert property ( // R20
		(st.state == sbc_pkg::ST_STOP || st.state == sbc_pkg::ST_WATCH) |->
		!o_main_osc_en && !o_cpu_clk_en && !o_periph_clk_en)
		else $error("main oscillator or clocks running in stop or watch");

	entry_clocks_a: assert property ( // R8
		(st.state == sbc_pkg::ST_ENTRY) |-> o_cpu_clk_en && o_wdt_clk_en && o_periph_clk_en)
		else $error("cpu stopped during entry latency");

	reject_sticky_a: assert property ( // R10
		(st.rejected && !(i_rd && i_addr == sbc_pkg::ADDR_STATUS)) |=> st.rejected)
		else $error("rejected flag lost before status read");

endmodule

`default_nettype wire

// *** verification/irq_source_model.sv ***
// interrupt source and cpu flag model for the standby bench
// assumes the bench asks for requests on the machine clock
`default_nettype none

module irq_source_model (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_nrst,
	// bench requests
	input wire logic i_raise,
	input wire logic i_accept,
	// to the controller
	output logic o_irq_pending,
	output logic o_ccr_accepts
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// request held as a level until withdrawn
	// ----------------------------------------
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_irq_pending <= 1'h0;
			o_ccr_accepts <= 1'h0;
		end else begin
			o_irq_pending <= i_raise;
			o_ccr_accepts <= i_accept;
		end
	end
endmodule

`default_nettype wire

// *** verification/tb.sv ***
// bench for the standby controller: register tasks and a mode table
// assumes the irq source model and a 200 MHz machine clock
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clk = 1'h0;
	logic nrst = 1'h0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic raise = 1'h0;
	logic accept = 1'h0;
	logic wdt = 1'h0;
	logic [1:0] mon = 2'h2;
	logic [7:0] rdata, d;
	logic [1:0] rmode;
	logic irq, acc, svc, rnext, cpu_en, wdt_en, per_en, osc_en, keep, wrun, force_cr, hold, hiz;
	logic [7:0] ctl [6] = '{8'h40, 8'h90, 8'h20, 8'h30, 8'hf0, 8'h60};
	logic [1:0] mode [6] = '{2'h2, 2'h2, 2'h3, 2'h0, 2'h0, 2'h1};
	logic [3:0] est [6] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h5, 4'h7};
	int stab [6] = '{0, 200, 0, 0, 400, 0};
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n;

	// ----------------------------------------
	// design and partner
	// ----------------------------------------
	standby_mode_controller u_standby_mode_controller (
		.i_mclk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .i_irq_pending(irq), .i_ccr_accepts(acc),
		.i_clock_mode_monitor(mon), .i_hw_wdt_standby(wdt), .o_service_int(svc),
		.o_resume_next(rnext), .o_cpu_clk_en(cpu_en), .o_wdt_clk_en(wdt_en),
		.o_periph_clk_en(per_en), .o_main_osc_en(osc_en), .o_sub_cr_keep(keep),
		.o_hw_wdt_run(wrun), .o_force_main_cr(force_cr), .o_resume_mode(rmode),
		.o_pin_hold(hold), .o_pin_hiz(hiz));
	irq_source_model u_irq_source_model (
		.i_mclk(clk), .i_nrst(nrst), .i_raise(raise), .i_accept(accept),
		.o_irq_pending(irq), .o_ccr_accepts(acc));

	// ----------------------------------------
	// clock, timeout and tasks
	// ----------------------------------------
	initial begin
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("errors %0d of %0d compares", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic write(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
		#1;
	endtask

	task automatic read(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1;
		v = rdata;
	endtask

	task automatic wait_run(input int lim);
		n = 0;
		while (cpu_en !== 1'h1 && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask

	task automatic do_reset();
		@(posedge clk);
		nrst <= 1'h0;
		repeat (8) @(posedge clk);
		#1;
		check("force", force_cr, 12'h1);
		check("rmode", rmode, 12'h2);
		@(posedge clk);
		nrst <= 1'h1;
		wait_run(1000);
		check("boot", 12'(n >= 598 && n <= 606), 12'h1);
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		do_reset();
		write(4'h0, 8'h10);
		read(4'h0, d);
		check("ctrl", d, 12'h10);
		read(4'h7, d);
		check("unmapped", d, 12'h0);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			mon <= mode[i];
			wdt <= i[0];
			accept <= ~i[0];
			write(4'h0, ctl[i]);
			n = 0;
			while (cpu_en === 1'h1 && n < 20) begin
				@(posedge clk);
				#1;
				n++;
			end
			check("entry", 12'(n), 12'h4);
			read(4'h1, d);
			check("state", d[3:0], est[i]);
			check("saved", d[5:4], mode[i]);
			check("hold", hold, est[i] >= 5 && !ctl[i][4]);
			check("hiz", hiz, est[i] >= 5 && ctl[i][4]);
			check("periph", per_en, est[i] == 4);
			check("wdtclk", wdt_en, 12'h0);
			check("osc", osc_en, est[i] == 4 || est[i] == 6);
			check("keep", keep, wdt);
			check("wrun", wrun, wdt);
			@(posedge clk);
			raise <= 1'h1;
			wait_run(5000);
			check("wake", 12'(n >= stab[i] && n <= stab[i] + 5), 12'h1);
			check("service", svc, accept);
			check("resume", rnext, !accept);
			check("mode", rmode, mode[i]);
			@(posedge clk);
			raise <= 1'h0;
		end
		@(posedge clk);
		mon <= 2'h2;
		accept <= 1'h0;
		raise <= 1'h1;
		repeat (2) @(posedge clk);
		write(4'h0, 8'h40);
		repeat (8) @(posedge clk);
		raise <= 1'h0;
		#1;
		check("kept", cpu_en, 12'h1);
		read(4'h1, d);
		check("reject", d, 12'h92);
		repeat (8) @(posedge clk);
		read(4'h1, d);
		check("after", d, 12'h12);
		do_reset();
		read(4'h1, d);
		check("rstwake", d[6], 12'h1);
		finish_test();
	end
endmodule

`default_nettype wire
